// file: adctrc_pkg.sv
`default_nettype none
package adctrc_pkg;

	localparam int NCONV = 2;

	// Byte offsets inside one converter's register window
	localparam logic [6:0] OFS_CTL1 = 7'h00;
	localparam logic [6:0] OFS_CTL2 = 7'h04;
	localparam logic [6:0] OFS_CTL3 = 7'h08;
	localparam logic [6:0] OFS_CTL4 = 7'h0c;
	localparam logic [6:0] OFS_CHAN = 7'h10;
	localparam logic [6:0] OFS_SCAN = 7'h14;
	// Global registers
	localparam logic [8:0] OFS_STS = 9'h100;
	localparam logic [8:0] OFS_MSK = 9'h104;
	// Address bits: global space, converter select, result buffer window
	localparam int GLOBAL_BIT = 8;
	localparam int INST_BIT   = 7;
	localparam int BUF_BIT    = 6;
	localparam int AW         = 9;

	// Control one fields
	localparam int CTL1_ON_BIT    = 15;
	localparam int CTL1_RES_BIT   = 10;
	localparam int CTL1_SRC_HI    = 7;
	localparam int CTL1_SRC_LO    = 5;
	localparam int CTL1_GRP_BIT   = 4;
	localparam int CTL1_START_BIT = 1;
	localparam int CTL1_BUSY_BIT  = 0;
	localparam logic [15:0] CTL1_WMASK = 16'hfffc;
	// Control two fields
	localparam int CTL2_SCAN_BIT = 10;
	localparam int CTL2_SMPI_LO  = 2;
	localparam int SMPI_W        = 5;
	// Control three / four fields
	localparam int CTL3_DIV_W    = 8;
	localparam int CTL4_DMA_BIT  = 8;

	localparam logic [15:0] CTL_RST  = 16'h0000;
	localparam logic [31:0] SCAN_RST = 32'h0000_0000;

	// Trigger source codes with the group bit clear
	localparam logic [2:0] SRC_MANUAL  = 3'h0;
	localparam logic [2:0] SRC_TMR3    = 3'h2;
	localparam logic [2:0] SRC_SEV_PRI = 3'h3;
	localparam logic [2:0] SRC_TMR5    = 3'h4;
	localparam logic [2:0] SRC_SEV_SEC = 3'h5;

	localparam int NPWM      = 7;
	localparam int RES_HI_W  = 12;
	localparam int RES_LO_W  = 10;
	localparam int CHAN_W    = 5;
	localparam int NSCAN     = 32;
	localparam int BUF_DEPTH = 16;
	localparam int BUF_AW    = 4;

	typedef enum logic {ST_IDLE, ST_CONV} adctrc_state_e;

	typedef struct packed {
		logic [CHAN_W-1:0]   chan;
		logic [RES_HI_W-1:0] data;
	} adctrc_result_s;

endpackage
`default_nettype wire

// file: adctrc_result_mem.sv
`timescale 1ns/1ps
`default_nettype none
module adctrc_result_mem #(
	parameter int W     = 12,
	parameter int DEPTH = 16,
	parameter int MAW   = 4
) (
	input  wire logic           sys_clk_i,
	input  wire logic           we_i,
	input  wire logic [MAW-1:0] waddr_i,
	input  wire logic [W-1:0]   wdata_i,
	input  wire logic           re_i,
	input  wire logic [MAW-1:0] raddr_i,
	output logic      [W-1:0]   rdata_o
);

	logic [W-1:0] mem_r [DEPTH];

	always_ff @(posedge sys_clk_i)
	begin
		if (we_i)
			mem_r[waddr_i] <= wdata_i;
	end

	// Read data held between reads so the bus can pick it up a cycle later
	always_ff @(posedge sys_clk_i)
	begin
		if (re_i)
			rdata_o <= mem_r[raddr_i];
	end

endmodule
`default_nettype wire

// file: adctrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module adctrc_top
	import adctrc_pkg::*;
(
	input  wire logic                         sys_clk_i,
	input  wire logic                         srst_i,
	input  wire logic                         hsel_i,
	input  wire logic [31:0]                  haddr_i,
	input  wire logic [1:0]                   htrans_i,
	input  wire logic                         hwrite_i,
	input  wire logic [2:0]                   hsize_i,
	input  wire logic [31:0]                  hwdata_i,
	input  wire logic                         hready_i,
	output wire logic [31:0]                  hrdata_o,
	output wire logic                         hreadyout_o,
	output wire logic                         hresp_o,
	input  wire logic [NPWM-1:0]              pwm_gen_trig_i,
	input  wire logic                         pwm_sev_pri_i,
	input  wire logic                         pwm_sev_sec_i,
	input  wire logic                         tmr3_trig_i,
	input  wire logic                         tmr5_trig_i,
	input  wire logic [NCONV-1:0]             conv_done_i,
	input  wire logic [NCONV-1:0][RES_HI_W-1:0] conv_data_i,
	output wire logic [NCONV-1:0]             conv_start_o,
	output wire logic [NCONV-1:0]             conv_tick_o,
	output wire logic [NCONV-1:0]             conv_res12_o,
	output wire logic [NCONV-1:0][CHAN_W-1:0] conv_chan_o,
	output wire logic [NCONV-1:0]             dma_req_o,
	output wire adctrc_result_s [NCONV-1:0]   dma_res_o,
	output wire logic                         irq_o
);

	logic          wr_pend_r;
	logic          rd_pend_r;
	logic [AW-1:0] addr_r;
	logic          hready_r;
	logic [31:0]   hrdata_r;
	logic [NCONV-1:0] sts_r;
	logic [NCONV-1:0] msk_r;
	logic          irq_r;

	// Bus decode
	wire            accept   = hsel_i & htrans_i[1] & hready_i;
	wire            rd_take  = accept & ~hwrite_i;
	wire            wr_glob  = wr_pend_r & addr_r[GLOBAL_BIT];
	wire            wr_sts   = wr_glob & (addr_r == OFS_STS);
	wire            wr_msk   = wr_glob & (addr_r == OFS_MSK);
	wire [6:0]      loc_off  = addr_r[6:0];
	wire [BUF_AW-1:0] buf_raddr = haddr_i[BUF_AW+1:2];

	wire [NCONV-1:0]       grp_evt;
	wire [NCONV-1:0][31:0] rd_word;

	// Event set wins over a write-one-to-clear in the same cycle
	wire [NCONV-1:0] sts_clr = wr_sts ? hwdata_i[NCONV-1:0] : '0;
	wire [NCONV-1:0] sts_nxt = (sts_r & ~sts_clr) | grp_evt;
	wire [NCONV-1:0] msk_nxt = wr_msk ? hwdata_i[NCONV-1:0] : msk_r;

	wire [31:0] glob_word =
		(addr_r == OFS_STS) ? {{(32-NCONV){1'b0}}, sts_r} :
		(addr_r == OFS_MSK) ? {{(32-NCONV){1'b0}}, msk_r} : 32'h0000_0000;
	wire [31:0] rd_mux = addr_r[GLOBAL_BIT] ? glob_word
		: rd_word[addr_r[INST_BIT]];

	// Reads take one wait state so the buffer's registered data can land
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= '0;
			hready_r  <= 1'b1;
			hrdata_r  <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_r <= accept & hwrite_i;
			rd_pend_r <= rd_take;
			if (accept)
				addr_r <= haddr_i[AW-1:0];
			hready_r <= ~rd_take;
			if (rd_pend_r)
				hrdata_r <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			sts_r <= '0;
			msk_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			sts_r <= sts_nxt;
			msk_r <= msk_nxt;
			irq_r <= |(sts_nxt & msk_nxt);
		end
	end

	assign hrdata_o    = hrdata_r;
	assign hreadyout_o = hready_r;
	assign hresp_o     = 1'b0;
	assign irq_o       = irq_r;

	// Next selected channel above the current one, wrapping round
	function automatic logic [CHAN_W-1:0] scan_next(
		input logic [NSCAN-1:0]  sel,
		input logic [CHAN_W-1:0] cur
	);
		logic [CHAN_W-1:0] nxt;
		logic              found;
		logic [CHAN_W-1:0] idx;
		nxt   = cur;
		found = 1'b0;
		for (int k = 1; k <= NSCAN; k++)
		begin
			idx = cur + CHAN_W'(k);
			if (!found && sel[idx])
			begin
				nxt   = idx;
				found = 1'b1;
			end
		end
		return nxt;
	endfunction

	genvar g;
	generate
		for (g = 0; g < NCONV; g++)
		begin : conv
			logic [15:0]         ctl1_r;
			logic [15:0]         ctl2_r;
			logic [15:0]         ctl3_r;
			logic [15:0]         ctl4_r;
			logic [15:0]         chan_r;
			logic [NSCAN-1:0]    scan_r;
			adctrc_state_e       st_r;
			logic [CTL3_DIV_W-1:0] tad_cnt_r;
			logic                tick_r;
			logic                start_r;
			logic [CHAN_W-1:0]   cur_r;
			logic [SMPI_W-1:0]   cnt_r;
			logic                dma_req_r;
			adctrc_result_s      dma_res_r;
			logic [RES_HI_W-1:0] buf_rdata;

			// Only the first converter keeps the resolution bit
			localparam logic [15:0] WMASK = (g == 0) ? CTL1_WMASK
				: (CTL1_WMASK & ~(16'h0001 << CTL1_RES_BIT));

			wire wr_here = wr_pend_r & ~addr_r[GLOBAL_BIT]
				& (addr_r[INST_BIT] == 1'(g)) & ~addr_r[BUF_BIT];
			wire wr_ctl1 = wr_here & (loc_off == OFS_CTL1);
			wire wr_ctl2 = wr_here & (loc_off == OFS_CTL2);
			wire wr_ctl3 = wr_here & (loc_off == OFS_CTL3);
			wire wr_ctl4 = wr_here & (loc_off == OFS_CTL4);
			wire wr_chan = wr_here & (loc_off == OFS_CHAN);
			wire wr_scan = wr_here & (loc_off == OFS_SCAN) & (g == 0);

			wire       on      = ctl1_r[CTL1_ON_BIT];
			wire       grp_sel = ctl1_r[CTL1_GRP_BIT];
			wire [2:0] src     = ctl1_r[CTL1_SRC_HI:CTL1_SRC_LO];
			wire       res12   = (g == 0) & ctl1_r[CTL1_RES_BIT];
			wire       dma_en  = ctl4_r[CTL4_DMA_BIT];
			wire [SMPI_W-1:0] smpi =
				ctl2_r[CTL2_SMPI_LO+SMPI_W-1:CTL2_SMPI_LO];
			wire [CTL3_DIV_W-1:0] div = ctl3_r[CTL3_DIV_W-1:0];
			wire scan_en = (g == 0) & ctl2_r[CTL2_SCAN_BIT] & (|scan_r);
			wire soft_go = wr_ctl1 & hwdata_i[CTL1_START_BIT];
			wire busy    = (st_r == ST_CONV);

			// Trigger selection
			wire trig_pwm = (src != 3'h0)
				& pwm_gen_trig_i[3'(src - 3'h1)];
			wire trig_alt =
				(src == SRC_MANUAL)  ? soft_go :
				(src == SRC_TMR3)    ? tmr3_trig_i :
				(src == SRC_TMR5)    ? tmr5_trig_i :
				(src == SRC_SEV_PRI) ? pwm_sev_pri_i :
				(src == SRC_SEV_SEC) ? pwm_sev_sec_i : 1'b0;
			wire trig_hit = grp_sel ? trig_pwm : trig_alt;
			wire start_go = on & ~busy & trig_hit;

			// Buffer mode counts at most 16 samples; DMA mode up to 32
			wire [SMPI_W-1:0] limit = dma_en ? smpi
				: {1'b0, smpi[BUF_AW-1:0]};
			wire done_hit = busy & conv_done_i[g];
			wire grp_end  = done_hit & (cnt_r == limit);
			wire [RES_HI_W-1:0] result = res12 ? conv_data_i[g]
				: {{(RES_HI_W-RES_LO_W){1'b0}},
				   conv_data_i[g][RES_LO_W-1:0]};
			wire buf_we = done_hit & ~dma_en;
			wire buf_re = rd_take & ~haddr_i[GLOBAL_BIT]
				& (haddr_i[INST_BIT] == 1'(g)) & haddr_i[BUF_BIT];

			always_ff @(posedge sys_clk_i)
			begin
				if (srst_i)
				begin
					ctl1_r <= CTL_RST;
					ctl2_r <= CTL_RST;
					ctl3_r <= CTL_RST;
					ctl4_r <= CTL_RST;
					chan_r <= CTL_RST;
					scan_r <= SCAN_RST;
				end
				else
				begin
					if (wr_ctl1)
						ctl1_r <= hwdata_i[15:0] & WMASK;
					if (wr_ctl2)
						ctl2_r <= hwdata_i[15:0];
					if (wr_ctl3)
						ctl3_r <= hwdata_i[15:0];
					if (wr_ctl4)
						ctl4_r <= hwdata_i[15:0];
					if (wr_chan)
						chan_r <= hwdata_i[15:0];
					if (wr_scan)
						scan_r <= hwdata_i[NSCAN-1:0];
				end
			end

			// Conversion clock: one tick every div+1 cycles
			always_ff @(posedge sys_clk_i)
			begin
				if (srst_i || !on)
				begin
					tad_cnt_r <= '0;
					tick_r    <= 1'b0;
				end
				else
				begin
					tick_r    <= (tad_cnt_r == div);
					tad_cnt_r <= (tad_cnt_r == div) ? '0
						: tad_cnt_r + 1'b1;
				end
			end

			always_ff @(posedge sys_clk_i)
			begin
				if (srst_i)
				begin
					st_r    <= ST_IDLE;
					start_r <= 1'b0;
				end
				else
				begin
					start_r <= start_go;
					unique case (st_r)
						ST_IDLE:
							if (start_go)
								st_r <= ST_CONV;
						ST_CONV:
							if (conv_done_i[g] || !on)
								st_r <= ST_IDLE;
					endcase
				end
			end

			// Switching storage mode restarts the sample count
			always_ff @(posedge sys_clk_i)
			begin
				if (srst_i || !on || wr_ctl4)
					cnt_r <= '0;
				else if (done_hit)
					cnt_r <= grp_end ? '0 : cnt_r + 1'b1;
			end

			always_ff @(posedge sys_clk_i)
			begin
				if (srst_i)
					cur_r <= '0;
				else if (!scan_en)
					cur_r <= chan_r[CHAN_W-1:0];
				else if (done_hit || !scan_r[cur_r])
					cur_r <= scan_next(scan_r, cur_r);
			end

			// No buffering toward DMA: the controller must take each pulse
			always_ff @(posedge sys_clk_i)
			begin
				if (srst_i)
				begin
					dma_req_r <= 1'b0;
					dma_res_r <= '0;
				end
				else
				begin
					dma_req_r <= done_hit & dma_en;
					if (done_hit & dma_en)
						dma_res_r <= '{chan: cur_r, data: result};
				end
			end

			adctrc_result_mem #(
				.W     (RES_HI_W),
				.DEPTH (BUF_DEPTH),
				.MAW   (BUF_AW)
			) u_buf (
				.sys_clk_i (sys_clk_i),
				.we_i      (buf_we),
				.waddr_i   (cnt_r[BUF_AW-1:0]),
				.wdata_i   (result),
				.re_i      (buf_re),
				.raddr_i   (buf_raddr),
				.rdata_o   (buf_rdata)
			);

			assign rd_word[g] =
				addr_r[BUF_BIT] ? {20'h00000, buf_rdata} :
				(loc_off == OFS_CTL1) ? {16'h0000,
					ctl1_r[15:1], busy} :
				(loc_off == OFS_CTL2) ? {16'h0000, ctl2_r} :
				(loc_off == OFS_CTL3) ? {16'h0000, ctl3_r} :
				(loc_off == OFS_CTL4) ? {16'h0000, ctl4_r} :
				(loc_off == OFS_CHAN) ? {16'h0000, chan_r} :
				(loc_off == OFS_SCAN) ? scan_r : 32'h0000_0000;

			assign grp_evt[g]      = grp_end;
			assign conv_start_o[g] = start_r;
			assign conv_tick_o[g]  = tick_r;
			assign conv_chan_o[g]  = cur_r;
			assign dma_req_o[g]    = dma_req_r;
			assign dma_res_o[g]    = dma_res_r;
		end
	endgenerate

	// Resolution pin taken from a flop per converter
	logic [NCONV-1:0] res12_r;
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			res12_r <= '0;
		else
			res12_r <= {1'b0, conv[0].ctl1_r[CTL1_RES_BIT]};
	end
	assign conv_res12_o = res12_r;

endmodule
`default_nettype wire

// file: adctrc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adctrc_properties
	import adctrc_pkg::*;
(
	input wire logic                           sys_clk_i,
	input wire logic                           srst_i,
	input wire logic                           hsel_i,
	input wire logic [1:0]                     htrans_i,
	input wire logic                           hwrite_i,
	input wire logic                           hready_i,
	input wire logic                           hreadyout_o,
	input wire logic                           hresp_o,
	input wire logic [NCONV-1:0]               conv_done_i,
	input wire logic [NCONV-1:0][RES_HI_W-1:0] conv_data_i,
	input wire logic [NCONV-1:0]               conv_start_o,
	input wire logic [NCONV-1:0]               conv_res12_o,
	input wire logic [NCONV-1:0]               dma_req_o,
	input wire adctrc_result_s [NCONV-1:0]     dma_res_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);
	wire logic tk = hsel_i & htrans_i[1] & hready_i;
	sequence s_wait;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	a_res_only_ten:
	assert property (!conv_res12_o[1])
		else $error("second converter in 12-bit mode");
	a_ten_bit_data:
	assert property (dma_req_o[1] |-> dma_res_o[1].data ==
		{2'b00, $past(conv_data_i[1][9:0])})
		else $error("second converter result not 10-bit");
	a_dma_from_done:
	assert property ((dma_req_o & ~$past(conv_done_i)) == 2'b00)
		else $error("result request without conversion");
	a_dma_data_low:
	assert property (dma_req_o[0] |->
		dma_res_o[0].data[9:0] == $past(conv_data_i[0][9:0]))
		else $error("first converter result mismatch");
	a_start_single:
	assert property (conv_start_o[0] |=> !conv_start_o[0])
		else $error("start while busy");
	a_resp_okay:
	assert property (!hresp_o)
		else $error("bus response not okay");
	a_read_wait:
	assert property (tk && !hwrite_i |=> s_wait)
		else $error("read wait state wrong");
	a_write_ready:
	assert property (tk && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
endmodule
bind adctrc_top adctrc_properties chk_u (
	.sys_clk_i(sys_clk_i), .srst_i(srst_i), .hsel_i(hsel_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
	.conv_start_o(conv_start_o), .conv_res12_o(conv_res12_o),
	.dma_req_o(dma_req_o), .dma_res_o(dma_res_o)
);
`default_nettype wire

// file: adctrc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module adctrc_conv_model (
	input  wire logic            sys_clk_i,
	input  wire logic            srst_i,
	input  wire logic [2:0]      lat_i,
	input  wire logic [1:0]      start_i,
	input  wire logic [1:0][4:0] chan_i,
	output logic      [1:0]      done_o,
	output logic      [1:0][11:0] data_o
);
	logic [2:0] cnt [2];
	logic [4:0] ch [2];
	// Result carries the channel so a routing slip shows in the data
	always_ff @(posedge sys_clk_i)
	begin
		for (int n = 0; n < 2; n++)
		begin
			done_o[n] <= !srst_i && cnt[n] == 3'h1;
			// Idle data toggles so a stale capture cannot match
			data_o[n] <= srst_i ? 12'h000 :
				(cnt[n] == 3'h1) ? {7'h5a, ch[n]} : ~data_o[n];
			if (srst_i)
				cnt[n] <= 3'h0;
			else if (start_i[n])
				cnt[n] <= lat_i;
			else if (cnt[n] != 3'h0)
				cnt[n] <= cnt[n] - 3'h1;
			if (start_i[n])
				ch[n] <= chan_i[n];
		end
	end
endmodule
`default_nettype wire

// file: adctrc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module adctrc_top_test
	import adctrc_pkg::*;
	;
	logic                  sys_clk = 1'b0;
	logic                  srst    = 1'b1;
	logic [31:0]           haddr   = 32'h0;
	logic [31:0]           hwdata  = 32'h0;
	logic [1:0]            htrans  = 2'h0;
	logic                  hwrite  = 1'b0;
	logic [10:0]           trig    = 11'h000;
	logic [2:0]            lat     = 3'h3;
	logic [4:0]            lch, e;
	logic [31:0]           c1 [2];
	wire logic [31:0]      hrdata;
	wire logic             rdy, hresp, irq;
	wire logic [1:0]       start, tick, res12, dreq, done;
	wire logic [1:0][4:0]  chan;
	wire logic [1:0][11:0] cdata;
	wire adctrc_result_s [1:0] dres;
	int failures = 0, n_tests = 0, cyc = 0, gap = 0, last = 0, b;
	int nst [2] = '{0, 0};
	int nd [2]  = '{0, 0};
	adctrc_top dut_u (
		.sys_clk_i(sys_clk), .srst_i(srst), .hsel_i(1'b1),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
		.hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(hresp),
		.pwm_gen_trig_i(trig[6:0]), .pwm_sev_pri_i(trig[7]),
		.pwm_sev_sec_i(trig[8]), .tmr3_trig_i(trig[9]),
		.tmr5_trig_i(trig[10]), .conv_done_i(done),
		.conv_data_i(cdata), .conv_start_o(start), .conv_tick_o(tick),
		.conv_res12_o(res12), .conv_chan_o(chan), .dma_req_o(dreq),
		.dma_res_o(dres), .irq_o(irq)
	);
	adctrc_conv_model mdl_u (
		.sys_clk_i(sys_clk), .srst_i(srst), .lat_i(lat),
		.start_i(start), .chan_i(chan), .done_o(done), .data_o(cdata)
	);
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (tick[0] === 1'b1)
		begin
			gap <= cyc - last;
			last <= cyc;
		end
		if (start[0] === 1'b1)
			lch <= chan[0];
		for (int n = 0; n < 2; n++)
		begin
			nst[n] <= nst[n] + (start[n] === 1'b1);
			nd[n] <= nd[n] + (dreq[n] === 1'b1);
		end
	end
	task wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask
	task wt(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	// Ready is looked at mid-cycle so the edge's own update cannot race
	task rdy_w(output logic [31:0] d);
		int i;
		i = 0;
		@(negedge sys_clk);
		while (rdy !== 1'b1 && i < 16)
		begin
			i++;
			@(negedge sys_clk);
		end
		if (i >= 16)
		begin
			failures++;
			wrap_up();
		end
		d = hrdata;
		@(posedge sys_clk);
	endtask
	task xfer(input logic w, input logic [8:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [31:0] x;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {23'h0, a};
		rdy_w(x);
		htrans <= 2'h0;
		hwdata <= wd;
		rdy_w(rd);
	endtask
	task wr(input logic [8:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask
	task rchk(input string nm, input logic [8:0] a, input logic [31:0] x);
		logic [31:0] g;
		xfer(1'b0, a, 32'h0, g);
		chk(nm, x, g);
	endtask
	function logic [8:0] ra(input int n, input logic [6:0] o);
		return {1'b0, n[0], o};
	endfunction
	function logic [11:0] ed(input logic [4:0] c);
		return {7'h5a, c};
	endfunction
	function logic [4:0] nx(input logic [4:0] c);
		logic [31:0] sel;
		logic [4:0]  j;
		sel = 32'h8000_0005;
		j = c + 5'h1;
		while (!sel[j])
			j = j + 5'h1;
		return j;
	endfunction
	task ss(input int n);
		wr(ra(n, OFS_CTL1), c1[n] | 32'h2);
		wt(12);
	endtask
	task trg(input int n, input logic g, input logic [2:0] s, input int k,
		input logic x);
		wr(ra(n, OFS_CTL1), {16'h0, 1'b1, 7'h0, s, g, 4'h0});
		b = nst[n];
		trig[k] <= 1'b1;
		@(posedge sys_clk);
		trig[k] <= 1'b0;
		wt(12);
		chk("trigger start", {31'h0, x}, nst[n] - b);
	endtask
	task dv(input logic [7:0] d);
		wr(ra(0, OFS_CTL1), 32'h0);
		wr(ra(0, OFS_CTL3), {24'h0, d});
		wr(ra(0, OFS_CTL1), 32'h8000);
		wt(2 * d + 8);
		chk("tick gap", d + 32'h1, gap);
	endtask
	initial
	begin
		#1000000;
		failures++;
		wrap_up();
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		rchk("ctl2 reset", ra(0, OFS_CTL2), 32'h0);
		rchk("unmapped", 9'h1f0, 32'h0);
		for (int k = 0; k < 7; k++)
			trg(0, 1'b1, k[2:0] + 3'h1, k, 1'b1);
		trg(0, 1'b1, 3'h3, 0, 1'b0);
		trg(0, 1'b0, SRC_SEV_PRI, 7, 1'b1);
		trg(0, 1'b0, SRC_SEV_SEC, 8, 1'b1);
		trg(0, 1'b0, SRC_SEV_PRI, 2, 1'b0);
		for (int n = 0; n < 2; n++)
		begin
			trg(n, 1'b0, SRC_TMR3, 9, 1'b1);
			trg(n, 1'b0, SRC_TMR5, 10, 1'b1);
			trg(n, 1'b0, SRC_TMR3, 10, 1'b0);
		end
		dv(8'h00);
		dv(8'h03);
		dv(8'hff);
		wr(ra(1, OFS_CTL1), 32'h8400);
		rchk("ctl1 second", ra(1, OFS_CTL1), 32'h8000);
		wr(ra(0, OFS_CTL1), 32'h8400);
		rchk("ctl1 first", ra(0, OFS_CTL1), 32'h8400);
		wt(2);
		chk("res12", 32'h1, {30'h0, res12});
		wr(OFS_STS, 32'h3);
		wr(OFS_MSK, 32'h3);
		wr(ra(0, OFS_CTL2), 32'h44);
		wr(ra(0, OFS_CHAN), 32'h3);
		wr(ra(0, OFS_CTL4), 32'h100);
		c1[0] = 32'h8400;
		b = nd[0];
		repeat (17) ss(0);
		chk("irq dma", 32'h0, {31'h0, irq});
		chk("dma count", 32'd17, nd[0] - b);
		chk("dma res", {5'h3, ed(5'h3)}, dres[0]);
		ss(0);
		chk("irq dma", 32'h1, {31'h0, irq});
		rchk("status", OFS_STS, 32'h1);
		wr(OFS_STS, 32'h1);
		// The clear lands on the edge the write returns at; look after it
		wt(1);
		chk("irq clear", 32'h0, {31'h0, irq});
		wr(ra(1, OFS_CTL2), 32'h44);
		wr(ra(1, OFS_CHAN), 32'h5);
		wr(ra(1, OFS_CTL4), 32'h0);
		c1[1] = 32'h8000;
		b = nd[1];
		ss(1);
		chk("irq buffer", 32'h0, {31'h0, irq});
		ss(1);
		chk("irq buffer", 32'h1, {31'h0, irq});
		chk("no dma", 32'h0, nd[1] - b);
		rchk("buf 0", ra(1, 7'h40), {20'h0, ed(5'h5) & 12'h3ff});
		rchk("buf 1", ra(1, 7'h44), {20'h0, ed(5'h5) & 12'h3ff});
		// Second converter through DMA must still deliver only ten bits
		wr(ra(1, OFS_CTL4), 32'h100);
		b = nd[1];
		ss(1);
		chk("dma count 1", 32'h1, nd[1] - b);
		chk("dma res 1", {5'h5, ed(5'h5) & 12'h3ff}, dres[1]);
		lat <= 3'h6;
		wr(ra(0, OFS_SCAN), 32'h8000_0005);
		wr(ra(0, OFS_CTL2), 32'h400);
		c1[0] = 32'h8000;
		ss(0);
		repeat (4)
		begin
			e = nx(lch);
			ss(0);
			chk("scan chan", {27'h0, e}, {27'h0, lch});
		end
		wrap_up();
	end
endmodule
`default_nettype wire
